// [design/aws_pkg.sv]
package aws_pkg;

  // Task-file register select
  localparam int         TF_ADDR_W      = 3;
  localparam logic [2:0] REG_DATA       = 3'h0;
  localparam logic [2:0] REG_ERROR      = 3'h1;
  localparam logic [2:0] REG_SCOUNT     = 3'h2;
  localparam logic [2:0] REG_SNUM       = 3'h3;
  localparam logic [2:0] REG_CYL_LO     = 3'h4;
  localparam logic [2:0] REG_CYL_HI     = 3'h5;
  localparam logic [2:0] REG_DEVHEAD    = 3'h6;
  localparam logic [2:0] REG_CMD_STATUS = 3'h7;

  // Command codes and field positions
  localparam logic [7:0] CMD_WRITE_SECT   = 8'h30;
  localparam int         CMD_RETRY_BIT    = 0;
  localparam int         DH_LBA_BIT       = 6;
  localparam int         DH_HEAD_MSB      = 3;
  localparam int         CTRL_SRST_BIT    = 2;
  localparam int         CTRL_NIEN_BIT    = 1;
  localparam logic [7:0] CHS_FIRST_SECTOR = 8'h01;

  // Sector framing
  localparam int         WORDS_PER_SECTOR = 256;
  localparam logic [7:0] LAST_WORD        = 8'(WORDS_PER_SECTOR - 1);
  localparam logic [8:0] FULL_COUNT       = 9'h100;

  // Response budgets, each in its printed unit, then in cycles
  localparam longint unsigned CLK_MHZ        = 250;
  localparam longint unsigned BUSY_TIME_NS   = 400;
  localparam longint unsigned DRQ_TIME_US    = 700;
  localparam longint unsigned REBUSY_TIME_US = 5;
  localparam longint unsigned READY_TIME_S   = 31;
  localparam longint unsigned XFER_TIME_S    = 30;
  localparam longint unsigned BUSY_CYCLES    = BUSY_TIME_NS * CLK_MHZ / 1000;
  localparam longint unsigned DRQ_CYCLES     = DRQ_TIME_US * CLK_MHZ;
  localparam longint unsigned REBUSY_CYCLES  = REBUSY_TIME_US * CLK_MHZ;
  localparam longint unsigned READY_CYCLES   = READY_TIME_S * CLK_MHZ * 1000000;
  localparam longint unsigned XFER_CYCLES    = XFER_TIME_S * CLK_MHZ * 1000000;
  localparam int              BUDGET_W       = 34;

  // Command block registers as the host sees them
  typedef struct packed {
    logic [7:0] devHead;
    logic [7:0] cylHigh;
    logic [7:0] cylLow;
    logic [7:0] sectorNumber;
    logic [7:0] sectorCount;
  } aws_taskfile_t;

  localparam aws_taskfile_t TF_RESET = 40'h00_00_00_01_01;

  // Status byte, bit 7 first
  typedef struct packed {
    logic busy;
    logic ready;
    logic fault;
    logic seekDone;
    logic dataReq;
    logic corrected;
    logic index;
    logic error;
  } aws_status_t;

  // Error byte, bit 7 first
  typedef struct packed {
    logic crcError;
    logic uncorrectable;
    logic zero5;
    logic sectorNotFoundFlag;
    logic zero3;
    logic commandAbortedFlag;
    logic trackZeroMissingFlag;
    logic addressMarkMissingFlag;
  } aws_error_t;

  typedef enum logic [2:0] {
    AWS_RESET,
    AWS_SPINUP,
    AWS_IDLE,
    AWS_ACCEPT,
    AWS_DRQ,
    AWS_MEDIA
  } aws_state_t;

endpackage : aws_pkg

// [design/aws_sync3.sv]
`timescale 1ns/1ps
module aws_sync3
  import aws_pkg::*;
#(
  parameter logic IDLE_LEVEL = 1'b1
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Pin side
  input  wire logic pinIn,
  // Settled level
  output logic      level
);

  logic stage1_q;
  logic stage2_q;
  logic stage3_q;
  logic level_q;

  // Three-stage chain; only stage two looks at stage one
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stage1_q <= IDLE_LEVEL;
      stage2_q <= IDLE_LEVEL;
      stage3_q <= IDLE_LEVEL;
    end else begin
      stage1_q <= pinIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
    end
  end

  // Level moves only when the two settled stages agree
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      level_q <= IDLE_LEVEL;
    end else if (stage2_q == stage3_q) begin
      level_q <= stage3_q;
    end
  end

  assign level = level_q;

endmodule : aws_sync3

// [design/aws_budget.sv]
`timescale 1ns/1ps
module aws_budget
  import aws_pkg::*;
#(
  parameter int              WIDTH = BUDGET_W,
  parameter longint unsigned LIMIT = 100
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Control
  input  wire logic restart,
  input  wire logic run,
  // Budget spent
  output logic      expired
);

  localparam logic [WIDTH-1:0] LimitW = WIDTH'(LIMIT);

  logic [WIDTH-1:0] count_q;

  if (WIDTH < 2 || WIDTH > 63 || LIMIT < 1 || LIMIT >= (64'h1 << WIDTH)) begin : g_badLimit
    $error("Budget limit does not fit the counter");
  end

  // Counter saturates at the limit so a stalled phase stays expired
  always_ff @(posedge ref_clk) begin
    if (rst || restart) begin
      count_q <= '0;
    end else if (run && count_q != LimitW) begin
      count_q <= count_q + 1'b1;
    end
  end

  assign expired = run && (count_q == LimitW);

endmodule : aws_budget

// [design/aws_write_sectors.sv]
`timescale 1ns/1ps
// What the document asks of the drive and the host
// (R01) Opcodes 30h and 31h write sectors; low bit set disables internal retries.
// (R02) The retry-disable bit is ignored only while the write cache is on.
// (R03) Sector data moves through the data register as 16-bit words.
// (R04) A sector count of zero means 256 sectors; otherwise the literal count.
// (R05) Address-mode bit set forms a 28-bit block address from the registers.
// (R06) Address-mode bit clear reads sector, cylinder and head of first sector.
// (R07) An uncorrectable error stops the command at the failing sector.
// (R08) Sector count ends holding sectors not transferred, zero unless an error.
// (R09) Address registers end holding the last sector transferred.
// (R10) Power-on, soft reset or bus reset shows busy within 400 ns.
// (R11) After any reset, ready set and busy clear within 31 seconds.
// (R12) Busy is set within 400 ns of a command register write.
// (R13) Data-in: busy clear, data request and interrupt within 30 s.
// (R14) Data-in: busy again within 10 us after the 256th word read.
// (R15) Data-out: busy clear and data request within 700 us of busy.
// (R16) Data-out: busy within 5 us after the 256th word write.
// (R17) Data-out: busy clear, ready and interrupt within 30 s of final busy.
// (R18) Non-data command: completion interrupt within 30 s of busy.
// (R19) Host answers any expired timeout with soft reset and a retry.
// (R20) Data request per 512-byte sector, interrupt once each sector is accepted.
module aws_write_sectors
  import aws_pkg::*;
#(
  parameter longint unsigned READY_LIMIT           = READY_CYCLES,
  parameter longint unsigned XFER_LIMIT            = XFER_CYCLES,
  parameter int              SECT_PER_TRACK        = 63,
  parameter int              HEAD_COUNT            = 16,
  parameter bit              IGNORE_RETRY_ON_CACHE = 1'b1
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  // Task-file register port
  input  wire logic                 tfWr,
  input  wire logic                 tfRd,
  input  wire logic [TF_ADDR_W-1:0] tfAddr,
  input  wire logic [15:0]          tfWdata,
  output logic      [15:0]          tfRdata,
  // Device control register
  input  wire logic                 ctrlWr,
  input  wire logic [7:0]           ctrlWdata,
  // Bus reset pin and interrupt
  input  wire logic                 hostResetN,
  output logic                      intrq,
  // Drive side
  input  wire logic                 spinupDone,
  input  wire logic                 writeCacheEn,
  input  wire logic                 mediaSectorDone,
  input  wire logic                 mediaUncorrectable,
  output logic                      mediaWordValid,
  output logic                      mediaWordLast,
  output logic      [15:0]          mediaWord,
  output logic                      mediaRetryDisable
);

  localparam logic [7:0]             SptW     = 8'(SECT_PER_TRACK);
  localparam logic [DH_HEAD_MSB:0]   LastHead = (DH_HEAD_MSB + 1)'(HEAD_COUNT - 1);

  if (SECT_PER_TRACK < 1 || SECT_PER_TRACK > 255 || HEAD_COUNT < 1 || HEAD_COUNT > 16) begin : g_badGeom
    $error("Drive geometry out of range");
  end
  // The block answers busy and data request one cycle after the cause
  if (BUSY_CYCLES < 1 || DRQ_CYCLES < 1 || REBUSY_CYCLES < 1) begin : g_badClock
    $error("Clock too slow for one-cycle responses");
  end

  aws_state_t    state_q;
  aws_taskfile_t tf_q;
  aws_taskfile_t tfNext;
  aws_error_t    errFlags_q;
  aws_status_t   statusNow;
  logic [8:0]    remaining_q;
  logic [7:0]    wordCnt_q;
  logic [27:0]   lbaNow;
  logic [15:0]   tfRdata_q;
  logic [15:0]   mediaWord_q;
  logic          mediaWordValid_q;
  logic          mediaWordLast_q;
  logic          srst_q;
  logic          nien_q;
  logic          ready_q;
  logic          errBit_q;
  logic          pending_q;
  logic          retryOff_q;
  logic          hostResetNS;
  logic          anyReset;
  logic          readyExpired;
  logic          xferExpired;
  logic          cmdWrite;
  logic          isWriteCmd;
  logic          dataWrite;
  logic          lastWord;
  logic          sectorOk;
  logic          sectorBad;
  logic          lastSector;
  logic          timedOut;
  logic          statusRead;

  // Bus reset pin arrives from outside the clock domain
  aws_sync3 #(.IDLE_LEVEL(1'b1)) u_resetSync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pinIn   (hostResetN),
    .level   (hostResetNS)
  );

  // Spin-up budget after any reset
  aws_budget #(.WIDTH(BUDGET_W), .LIMIT(READY_LIMIT)) u_readyBudget (
    .ref_clk (ref_clk),
    .rst     (rst),
    .restart (state_q == AWS_RESET),
    .run     (state_q == AWS_SPINUP),
    .expired (readyExpired)
  );

  // Media budget per sector, started by the last word of the sector
  aws_budget #(.WIDTH(BUDGET_W), .LIMIT(XFER_LIMIT)) u_xferBudget (
    .ref_clk (ref_clk),
    .rst     (rst),
    .restart (lastWord),
    .run     (state_q == AWS_MEDIA),
    .expired (xferExpired)
  );

  // Decoded host events
  assign anyReset   = ~hostResetNS | srst_q;
  assign cmdWrite   = tfWr && tfAddr == REG_CMD_STATUS && state_q == AWS_IDLE;
  assign isWriteCmd = tfWdata[7:1] == CMD_WRITE_SECT[7:1];                        // R01
  assign dataWrite  = tfWr && tfAddr == REG_DATA && state_q == AWS_DRQ;           // R03
  assign lastWord   = dataWrite && wordCnt_q == LAST_WORD;
  assign sectorOk   = state_q == AWS_MEDIA && mediaSectorDone && !mediaUncorrectable;
  assign sectorBad  = state_q == AWS_MEDIA && mediaSectorDone && mediaUncorrectable;
  assign timedOut   = state_q == AWS_MEDIA && xferExpired && !mediaSectorDone;
  assign lastSector = remaining_q == 9'h001;
  assign statusRead = tfRd && tfAddr == REG_CMD_STATUS;
  assign lbaNow     = {tf_q.devHead[DH_HEAD_MSB:0], tf_q.cylHigh, tf_q.cylLow, tf_q.sectorNumber};

  // Command sequencer; a reset event overrides every phase
  always_ff @(posedge ref_clk) begin
    if (rst || anyReset) begin
      state_q <= AWS_RESET;                                                      // R10
    end else begin
      case (state_q)
        AWS_RESET: begin
          state_q <= AWS_SPINUP;
        end
        AWS_SPINUP: begin
          if (spinupDone || readyExpired) begin
            state_q <= AWS_IDLE;                                                 // R11
          end
        end
        AWS_IDLE: begin
          if (cmdWrite && isWriteCmd) begin
            state_q <= AWS_ACCEPT;                                               // R12
          end
        end
        AWS_ACCEPT: begin
          state_q <= AWS_DRQ;                                                    // R15
        end
        AWS_DRQ: begin
          if (lastWord) begin
            state_q <= AWS_MEDIA;                                                // R16
          end
        end
        AWS_MEDIA: begin
          if (sectorBad || timedOut || (sectorOk && lastSector)) begin
            state_q <= AWS_IDLE;                                                 // R07 R17
          end else if (sectorOk) begin
            state_q <= AWS_DRQ;                                                  // R20
          end
        end
        default: begin
          state_q <= AWS_RESET;
        end
      endcase
    end
  end

  // Next address in the mode chosen by the host
  always_comb begin
    tfNext             = tf_q;
    tfNext.sectorCount = tf_q.sectorCount - 8'h01;
    if (tf_q.devHead[DH_LBA_BIT]) begin
      {tfNext.devHead[DH_HEAD_MSB:0], tfNext.cylHigh, tfNext.cylLow, tfNext.sectorNumber} =
        lbaNow + 28'h0000001;                                                    // R05
    end else if (tf_q.sectorNumber == SptW) begin
      tfNext.sectorNumber = CHS_FIRST_SECTOR;                                    // R06
      if (tf_q.devHead[DH_HEAD_MSB:0] == LastHead) begin
        tfNext.devHead[DH_HEAD_MSB:0]   = '0;
        {tfNext.cylHigh, tfNext.cylLow} = {tf_q.cylHigh, tf_q.cylLow} + 16'h0001;
      end else begin
        tfNext.devHead[DH_HEAD_MSB:0] = tf_q.devHead[DH_HEAD_MSB:0] + 1'b1;
      end
    end else begin
      tfNext.sectorNumber = tf_q.sectorNumber + 8'h01;
    end
  end

  // Task file: host writes only while idle, sequencer steps it per sector
  always_ff @(posedge ref_clk) begin
    if (rst || anyReset) begin
      tf_q <= TF_RESET;
    end else if (tfWr && state_q == AWS_IDLE) begin
      case (tfAddr)
        REG_SCOUNT:  tf_q.sectorCount  <= tfWdata[7:0];
        REG_SNUM:    tf_q.sectorNumber <= tfWdata[7:0];
        REG_CYL_LO:  tf_q.cylLow       <= tfWdata[7:0];
        REG_CYL_HI:  tf_q.cylHigh      <= tfWdata[7:0];
        REG_DEVHEAD: tf_q.devHead      <= tfWdata[7:0];
        default:     tf_q              <= tf_q;
      endcase
    end else if (sectorOk && lastSector) begin
      tf_q.sectorCount <= tfNext.sectorCount;                                    // R08 R09
    end else if (sectorOk) begin
      tf_q <= tfNext;                                                            // R08
    end
  end

  // Remaining sectors and word position within the sector
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      remaining_q <= 9'h000;
      wordCnt_q   <= 8'h00;
    end else begin
      if (cmdWrite && isWriteCmd) begin
        remaining_q <= (tf_q.sectorCount == 8'h00) ? FULL_COUNT : {1'b0, tf_q.sectorCount}; // R04
      end else if (sectorOk) begin
        remaining_q <= remaining_q - 9'h001;
      end
      if (state_q != AWS_DRQ) begin
        wordCnt_q <= 8'h00;
      end else if (dataWrite) begin
        wordCnt_q <= wordCnt_q + 8'h01;                                          // R03
      end
    end
  end

  // Word stream toward the media path; no buffering, the media side keeps pace
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mediaWordValid_q <= 1'b0;
      mediaWordLast_q  <= 1'b0;
      mediaWord_q      <= 16'h0000;
    end else begin
      mediaWordValid_q <= dataWrite;
      mediaWordLast_q  <= lastWord;
      if (dataWrite) begin
        mediaWord_q <= tfWdata;                                                  // R03
      end
    end
  end

  // Retry policy latched with the command
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      retryOff_q <= 1'b0;
    end else if (cmdWrite && isWriteCmd) begin
      retryOff_q <= tfWdata[CMD_RETRY_BIT] && !(IGNORE_RETRY_ON_CACHE && writeCacheEn); // R01 R02
    end
  end

  // Device control: soft reset holds the block until software drops it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      srst_q <= 1'b0;
      nien_q <= 1'b0;
    end else if (ctrlWr) begin
      srst_q <= ctrlWdata[CTRL_SRST_BIT];                                        // R10
      nien_q <= ctrlWdata[CTRL_NIEN_BIT];
    end
  end

  // Ready and error flags; a fresh command clears old errors
  always_ff @(posedge ref_clk) begin
    if (rst || anyReset) begin
      ready_q    <= 1'b0;
      errBit_q   <= 1'b0;
      errFlags_q <= '0;
    end else begin
      if (state_q == AWS_SPINUP && (spinupDone || readyExpired)) begin
        ready_q <= 1'b1;                                                         // R11
      end
      if (cmdWrite) begin
        errBit_q                      <= !isWriteCmd;
        errFlags_q                    <= '0;
        errFlags_q.commandAbortedFlag <= !isWriteCmd;
      end else if (sectorBad || timedOut) begin
        errBit_q                      <= 1'b1;                                   // R07
        errFlags_q.commandAbortedFlag <= 1'b1;                                   // R07
      end
    end
  end

  // Interrupt pending: a new event wins over a status read in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst || anyReset) begin
      pending_q <= 1'b0;
    end else if ((cmdWrite && !isWriteCmd) || sectorOk || sectorBad || timedOut) begin
      pending_q <= 1'b1;                                                         // R17 R18 R20
    end else if (statusRead || cmdWrite) begin
      pending_q <= 1'b0;
    end
  end

  // Status byte built from the sequencer phase
  always_comb begin
    statusNow          = '0;
    statusNow.busy     = state_q inside {AWS_RESET, AWS_SPINUP, AWS_ACCEPT, AWS_MEDIA};
    statusNow.ready    = ready_q;
    statusNow.seekDone = ready_q;
    statusNow.dataReq  = state_q == AWS_DRQ;
    statusNow.error    = errBit_q;
  end

  // Register readback; only a write command is served, so data reads give zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tfRdata_q <= 16'h0000;
    end else if (tfRd) begin
      case (tfAddr)
        REG_DATA:       tfRdata_q <= 16'h0000;                                   // R13 R14
        REG_ERROR:      tfRdata_q <= {8'h00, errFlags_q};
        REG_SCOUNT:     tfRdata_q <= {8'h00, tf_q.sectorCount};
        REG_SNUM:       tfRdata_q <= {8'h00, tf_q.sectorNumber};
        REG_CYL_LO:     tfRdata_q <= {8'h00, tf_q.cylLow};
        REG_CYL_HI:     tfRdata_q <= {8'h00, tf_q.cylHigh};
        REG_DEVHEAD:    tfRdata_q <= {8'h00, tf_q.devHead};
        REG_CMD_STATUS: tfRdata_q <= {8'h00, statusNow};
        default:        tfRdata_q <= 16'h0000;
      endcase
    end
  end

  // Outputs
  assign tfRdata           = tfRdata_q;
  assign intrq             = pending_q && !nien_q;
  assign mediaWordValid    = mediaWordValid_q;
  assign mediaWordLast     = mediaWordLast_q;
  assign mediaWord         = mediaWord_q;
  assign mediaRetryDisable = retryOff_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_busyAfterCmd;
    cmdWrite && isWriteCmd && !anyReset |=> statusNow.busy && !statusNow.dataReq;
  endproperty
  a_busyAfterCmd: assert property (p_busyAfterCmd) else $error("No busy after write command"); // R12

  property p_drqAfterBusy;
    state_q == AWS_ACCEPT && !anyReset |=> statusNow.dataReq && !statusNow.busy;
  endproperty
  a_drqAfterBusy: assert property (p_drqAfterBusy) else $error("No data request after busy"); // R15

  property p_abortIrq;
    cmdWrite && !isWriteCmd && !anyReset |=> pending_q && errFlags_q.commandAbortedFlag && !statusNow.busy;
  endproperty
  a_abortIrq: assert property (p_abortIrq) else $error("Rejected command not completed"); // R18

  property p_rebusy;
    lastWord && !anyReset |=> statusNow.busy && !statusNow.dataReq;
  endproperty
  a_rebusy: assert property (p_rebusy) else $error("No busy after last word"); // R16

  property p_resetBusy;
    anyReset |=> statusNow.busy && !ready_q;
  endproperty
  a_resetBusy: assert property (p_resetBusy) else $error("Reset did not show busy"); // R10

  property p_ready;
    state_q == AWS_SPINUP && spinupDone && !anyReset |=> statusNow.ready && !statusNow.busy;
  endproperty
  a_ready: assert property (p_ready) else $error("Ready not reported after spin-up"); // R11

  property p_count256;
    cmdWrite && isWriteCmd && tf_q.sectorCount == 8'h00 |=> remaining_q == FULL_COUNT;
  endproperty
  a_count256: assert property (p_count256) else $error("Zero count not taken as 256"); // R04

  property p_stop;
    sectorBad && !anyReset |=> state_q == AWS_IDLE && $stable(tf_q) && errBit_q ##1 !statusNow.dataReq;
  endproperty
  a_stop: assert property (p_stop) else $error("Write continued past failing sector"); // R07

  property p_finish;
    sectorOk && lastSector && !anyReset |=>
      tf_q.sectorCount == 8'h00 && lbaNow == $past(lbaNow) && pending_q && !statusNow.busy;
  endproperty
  a_finish: assert property (p_finish) else $error("Bad completion values"); // R08

  property p_nextSector;
    sectorOk && !lastSector && !anyReset |=>
      statusNow.dataReq && pending_q && tf_q.sectorCount == $past(tf_q.sectorCount) - 8'h01;
  endproperty
  a_nextSector: assert property (p_nextSector) else $error("Next sector not requested"); // R20

  property p_lbaStep;
    sectorOk && !lastSector && !anyReset && tf_q.devHead[DH_LBA_BIT] |=> lbaNow == $past(lbaNow) + 28'h0000001;
  endproperty
  a_lbaStep: assert property (p_lbaStep) else $error("Block address did not step"); // R05

  property p_retry;
    cmdWrite && isWriteCmd |=>
      mediaRetryDisable == ($past(tfWdata[CMD_RETRY_BIT]) && !(IGNORE_RETRY_ON_CACHE && $past(writeCacheEn)));
  endproperty
  a_retry: assert property (p_retry) else $error("Retry policy wrong"); // R02

  property p_word;
    dataWrite |=> mediaWordValid && mediaWord == $past(tfWdata);
  endproperty
  a_word: assert property (p_word) else $error("Data word not forwarded"); // R03

endmodule : aws_write_sectors

// [verif/aws_media_model.sv]
`timescale 1ns/1ps
module aws_media_model
  import aws_pkg::*;
#(
  parameter int DLY = 20
) (
  // Clock
  input  wire logic       ref_clk,
  // Drive side of the block
  input  wire logic       mediaWordLast,
  input  wire logic [7:0] failAt,
  input  wire logic [7:0] stallAt,
  output logic            mediaSectorDone,
  output logic            mediaUncorrectable
);
  int   cnt    = 0;
  int   sect   = 0;
  logic done_q = 1'b0;
  logic unc_q  = 1'b0;
  // Slow media: a sector ends DLY cycles after its last word; one sector fails, one never answers
  always @(posedge ref_clk) begin
    done_q <= 1'b0;
    unc_q  <= 1'b0;
    if (mediaWordLast) cnt <= DLY;
    else if (cnt > 1) cnt <= cnt - 1;
    else if (cnt == 1) begin
      cnt    <= 0;
      done_q <= (sect != int'(stallAt));
      unc_q  <= (sect == int'(failAt));
      sect   <= sect + 1;
    end
  end
  assign mediaSectorDone    = done_q;
  assign mediaUncorrectable = unc_q;
endmodule : aws_media_model

// [verif/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import aws_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, tfWr = 1'b0, tfRd = 1'b0, ctrlWr = 1'b0, hostResetN = 1'b1;
  logic spinupDone = 1'b0, writeCacheEn = 1'b0;
  logic [2:0] tfAddr = 3'h0;
  logic [15:0] tfWdata = 16'h0000, d;
  logic [7:0] ctrlWdata = 8'h00, failAt = 8'hFF, stallAt = 8'hFF;
  wire logic [15:0] tfRdata, mediaWord;
  wire logic intrq, mediaSectorDone, mediaUncorrectable, mediaWordValid, mediaWordLast, mediaRetryDisable;
  int fails = 0, comparisons = 0;
  // Clock, short limits so spin-up and media timeouts stay quick
  always #2 ref_clk = ~ref_clk;
  aws_write_sectors #(.READY_LIMIT(50), .XFER_LIMIT(200)) i_dut (.ref_clk, .rst, .tfWr, .tfRd, .tfAddr,
    .tfWdata, .tfRdata, .ctrlWr, .ctrlWdata, .hostResetN, .intrq, .spinupDone, .writeCacheEn,
    .mediaSectorDone, .mediaUncorrectable, .mediaWordValid, .mediaWordLast, .mediaWord, .mediaRetryDisable);
  aws_media_model i_media (.ref_clk, .mediaWordLast, .failAt, .stallAt, .mediaSectorDone, .mediaUncorrectable);
  // Shared access and compare tasks; strobes drop a full cycle apart
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task rd(input logic [2:0] a);
    @(negedge ref_clk) begin tfAddr = a; tfRd = 1'b1; end
    @(negedge ref_clk) begin tfRd = 1'b0; d = tfRdata; end
  endtask : rd
  task wr(input logic [2:0] a, input logic [15:0] v);
    @(negedge ref_clk) begin tfAddr = a; tfWdata = v; tfWr = 1'b1; end
    @(negedge ref_clk) tfWr = 1'b0;
  endtask : wr
  task ctl(input logic [7:0] v);
    @(negedge ref_clk) begin ctrlWdata = v; ctrlWr = 1'b1; end
    @(negedge ref_clk) ctrlWr = 1'b0;
  endtask : ctl
  task waitst(input logic [7:0] m, input logic [7:0] v);
    for (int i = 0; i < 400; i++) begin
      rd(REG_CMD_STATUS);
      if ((d[7:0] & m) === v) break;
    end
    chk(d & {8'h00, m}, {8'h00, v});
  endtask : waitst
  task load(input aws_taskfile_t t, input logic [7:0] c);
    for (int i = 0; i < 5; i++) wr(3'(i + 2), {8'h00, t[i*8 +: 8]});
    wr(REG_CMD_STATUS, {8'h00, c});
  endtask : load
  task cmpTf(input aws_taskfile_t t);
    for (int i = 0; i < 5; i++) begin
      rd(3'(i + 2));
      chk(d, {8'h00, t[i*8 +: 8]});
    end
  endtask : cmpTf
  // One sector: wait for the data request, push 256 words, then busy until media ends
  task sector(input logic [7:0] s);
    waitst(8'h88, 8'h08);
    for (int w = 0; w < WORDS_PER_SECTOR; w++) wr(REG_DATA, {s, 8'(w)});
    chk(mediaWord, {s, 8'hFF});
    chk({14'h0000, mediaWordValid, mediaWordLast}, 16'h0003);
    rd(REG_CMD_STATUS);
    chk(d & 16'h0088, 16'h0080);
    for (int i = 0; i < 300 && intrq !== 1'b1; i++) @(negedge ref_clk);
    chk({15'h0000, intrq}, 16'h0001);
  endtask : sector
  task end_sim();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  // Watchdog well beyond the expected run of a few thousand cycles
  initial begin
    #200000;
    fails++;
    end_sim();
  end
  // Test sequence
  initial begin
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    rd(REG_CMD_STATUS);
    chk(d, 16'h0080);
    spinupDone = 1'b1;
    waitst(8'hFF, 8'h50);
    $display("test reset done");
    load(40'h45_30_20_10_02, 8'h31);
    chk({15'h0000, mediaRetryDisable}, 16'h0001);
    sector(8'h00);
    sector(8'h01);
    waitst(8'hFF, 8'h50);
    cmpTf(40'h45_30_20_11_00);
    $display("test block address write done");
    writeCacheEn = 1'b1;
    failAt = 8'd3;
    load(40'h02_00_00_3F_00, 8'h31);
    chk({15'h0000, mediaRetryDisable}, 16'h0000);
    sector(8'h02);
    sector(8'h03);
    waitst(8'h89, 8'h01);
    cmpTf(40'h03_00_00_01_FF);
    rd(REG_ERROR);
    chk(d, 16'h0004);
    $display("test chs error write done");
    writeCacheEn = 1'b0;
    stallAt = 8'd4;
    load(40'h40_00_00_07_01, 8'h30);
    chk({15'h0000, mediaRetryDisable}, 16'h0000);
    sector(8'h04);
    waitst(8'h89, 8'h01);
    cmpTf(40'h40_00_00_07_01);
    rd(REG_ERROR);
    chk(d, 16'h0004);
    ctl(8'h04);
    rd(REG_CMD_STATUS);
    chk(d & 16'h0080, 16'h0080);
    ctl(8'h00);
    waitst(8'hFF, 8'h50);
    rd(REG_ERROR);
    chk(d, 16'h0000);
    load(40'h40_00_00_07_01, 8'h30);
    sector(8'h05);
    waitst(8'hFF, 8'h50);
    cmpTf(40'h40_00_00_07_00);
    $display("test timeout retry done");
    hostResetN = 1'b0;
    repeat (8) @(negedge ref_clk);
    rd(REG_CMD_STATUS);
    chk(d & 16'h0080, 16'h0080);
    hostResetN = 1'b1;
    waitst(8'hFF, 8'h50);
    wr(REG_CMD_STATUS, 16'h0020);
    rd(REG_ERROR);
    chk(d, 16'h0004);
    chk({15'h0000, intrq}, 16'h0001);
    ctl(8'h02);
    chk({15'h0000, intrq}, 16'h0000);
    $display("test resets and abort done");
    end_sim();
  end
endmodule : tb_top
